//--- common/dma_desc_defines.vh
// Purpose: Constants for the descriptor table parser
// Assumes: 32-bit APB, byte addresses
// Notes:   Offsets, fields, reset values and sizes
`ifndef DMA_DESC_DEFINES_VH
`define DMA_DESC_DEFINES_VH

// APB register offsets
`define REG_RD_BASE_LO     8'h00
`define REG_RD_BASE_HI     8'h04
`define REG_RD_LAST_PTR    8'h08
`define REG_RD_TABLE_SIZE  8'h0c
`define REG_WR_BASE_LO     8'h10
`define REG_WR_BASE_HI     8'h14
`define REG_WR_LAST_PTR    8'h18
`define REG_WR_TABLE_SIZE  8'h1c
`define REG_STATUS         8'h20
`define REG_ERROR          8'h24

// Reset values
`define TABLE_SIZE_RESET   7'h7f
`define LAST_PTR_NONE      8'hff

// Table layout
`define DESC_TABLE_OFFSET  64'h0000_0000_0000_0200
`define DESC_BEATS         3'h7
`define BEAT_SRC_LO        3'h0
`define BEAT_SRC_HI        3'h1
`define BEAT_DST_LO        3'h2
`define BEAT_DST_HI        3'h3
`define BEAT_CTRL          3'h4
`define DONE_FLAG          32'h0000_0001

// Control dword fields
`define CTRL_RSVD_HI       31
`define CTRL_RSVD_LO       25
`define CTRL_ID_HI         24
`define CTRL_ID_LO         18
`define CTRL_LEN_HI        17
`define CTRL_LEN_LO        0

// Error bits
`define ERR_ZERO_LEN       0
`define ERR_RSVD           1
`define ERR_ID             2
`define ERR_DONE_ORDER     3

// Descriptor FIFO
`define FIFO_DEPTH         32
`define FIFO_AW            5
`define FIFO_WIDTH         154

`endif

//--- rtl/dma_descriptor_table_parser.v
// Purpose: Fetches and decodes descriptor tables, queues them for the movers
// Assumes: Fetch and status ports are on pclk; one dword per fetch beat
// Notes:   Descriptor FIFO module sits in this file
// Operation
// - Read and write descriptors live in two separate tables of at most 128 entries.
// - Each entry is eight dwords; entry n starts n times 32 bytes in.
// - First descriptor sits 0x200 bytes above the programmed base for that direction.
// - Read descriptor dwords 0 and 1 give the host source address.
// - Read descriptor dwords 2 and 3 give the local destination address.
// - Write descriptor dwords 0 and 1 give the local source address.
// - Write descriptor dwords 2 and 3 give the host destination address.
// - Control bits 24 to 18 hold the identifier, zero at table start.
// - Control bits 17 to 0 hold the dword length, never zero.
// - Length up to one megabyte minus four is passed on unrounded.
// - Identifiers wrap to zero after the programmed table size value.
// - Descriptor count is the difference between old and new last pointer.
// - Status table below descriptors holds one word per entry, bit 0 done.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dma_desc_defines.vh"

module desc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_q;
    reg [AW:0]      rd_ptr_q;

    assign count     = wr_ptr_q - rd_ptr_q;
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_q[AW-1:0]];

    always @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule // desc_fifo

module dma_descriptor_table_parser (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         fetch_req,
    output reg  [63:0] fetch_addr,
    input  wire        fetch_gnt,
    input  wire        fetch_rvalid,
    input  wire [31:0] fetch_rdata,
    output reg         desc_valid,
    input  wire        desc_ready,
    output reg         desc_dir,
    output reg  [6:0]  desc_id,
    output reg  [17:0] desc_len_dw,
    output reg  [63:0] desc_src_addr,
    output reg  [63:0] desc_dst_addr,
    input  wire        done_valid,
    output reg         done_ready,
    input  wire        done_dir,
    input  wire [6:0]  done_id,
    output reg         stat_req,
    output reg  [63:0] stat_addr,
    output reg  [31:0] stat_data,
    input  wire        stat_gnt,
    output reg         busy
);
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ  = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_PUSH = 2'h3;

    reg [63:0] rd_base_q;
    reg [63:0] wr_base_q;
    reg [7:0]  rd_last_q;
    reg [7:0]  wr_last_q;
    reg [6:0]  rd_size_q;
    reg [6:0]  wr_size_q;
    reg [7:0]  rd_pend_q;
    reg [7:0]  wr_pend_q;
    reg [6:0]  rd_next_q;
    reg [6:0]  wr_next_q;
    reg [6:0]  rd_expect_q;
    reg [6:0]  wr_expect_q;
    reg [3:0]  err_q;
    reg [1:0]  state_q;
    reg [2:0]  beat_q;
    reg        cur_dir_q;
    reg [6:0]  cur_id_q;
    reg [31:0] src_lo_q;
    reg [31:0] src_hi_q;
    reg [31:0] dst_lo_q;
    reg [31:0] dst_hi_q;
    reg [31:0] ctrl_q;
    reg [31:0] rdata_d;
    reg        addr_ok;
    reg [3:0]  err_set;

    wire [`FIFO_AW:0]      fifo_count;
    wire                   fifo_in_ready;
    wire                   fifo_out_valid;
    wire [`FIFO_WIDTH-1:0] fifo_out_data;
    wire                   len_zero = (ctrl_q[`CTRL_LEN_HI:`CTRL_LEN_LO] == 18'h00000);
    wire                   push     = (state_q == ST_PUSH) && !len_zero;
    wire                   out_load = !desc_valid || desc_ready;
    wire                   setup    = psel && !penable;
    wire                   wr_acc   = psel && penable && pready && pwrite;
    wire                   rd_sel   = (rd_pend_q != 8'h00);
    wire                   start    = (state_q == ST_IDLE) && (rd_sel || (wr_pend_q != 8'h00));
    wire                   done_acc = done_valid && done_ready;
    wire [7:0]             rd_add;
    wire [7:0]             wr_add;

    // Count of new descriptors between old and new last pointer
    function [7:0] ptr_diff;
        input [7:0] old_p;
        input [7:0] wptr;
        input [6:0] size;
        reg   [8:0] t;
        begin
            t = 9'h000;
            if (old_p == `LAST_PTR_NONE) begin
                t = {1'b0, wptr} + 9'h001;
            end else if (wptr >= old_p) begin
                t = {1'b0, wptr} - {1'b0, old_p};
            end else begin
                t = {1'b0, wptr} + {2'b00, size} + 9'h001 - {1'b0, old_p};
            end
            ptr_diff = t[7:0];
        end
    endfunction

    // Identifier after id, wrapping at the table size
    function [6:0] id_next;
        input [6:0] id;
        input [6:0] size;
        begin
            id_next = (id == size) ? 7'h00 : id + 7'h01;
        end
    endfunction

    assign rd_add = (wr_acc && paddr[7:0] == `REG_RD_LAST_PTR) ?
                    ptr_diff(rd_last_q, pwdata[7:0], rd_size_q) : 8'h00;
    assign wr_add = (wr_acc && paddr[7:0] == `REG_WR_LAST_PTR) ?
                    ptr_diff(wr_last_q, pwdata[7:0], wr_size_q) : 8'h00;

    desc_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({cur_dir_q, ctrl_q[`CTRL_ID_HI:`CTRL_ID_LO],
                     ctrl_q[`CTRL_LEN_HI:`CTRL_LEN_LO],
                     src_hi_q, src_lo_q, dst_hi_q, dst_lo_q}),
        .out_valid (fifo_out_valid),
        .out_ready (out_load),
        .out_data  (fifo_out_data),
        .count     (fifo_count)
    );

    // Register read mux
    always @* begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr[7:0])
            `REG_RD_BASE_LO:    rdata_d = rd_base_q[31:0];
            `REG_RD_BASE_HI:    rdata_d = rd_base_q[63:32];
            `REG_RD_LAST_PTR:   rdata_d = {24'h000000, rd_last_q};
            `REG_RD_TABLE_SIZE: rdata_d = {25'h0000000, rd_size_q};
            `REG_WR_BASE_LO:    rdata_d = wr_base_q[31:0];
            `REG_WR_BASE_HI:    rdata_d = wr_base_q[63:32];
            `REG_WR_LAST_PTR:   rdata_d = {24'h000000, wr_last_q};
            `REG_WR_TABLE_SIZE: rdata_d = {25'h0000000, wr_size_q};
            `REG_STATUS:        rdata_d = {16'h0000, rd_pend_q[6:0], fifo_count, state_q, busy};
            `REG_ERROR:         rdata_d = {28'h0000000, err_q};
            default:            addr_ok = 1'b0;
        endcase
    end

    // Error events from parsing and completion
    always @* begin
        err_set = 4'h0;
        if (state_q == ST_PUSH) begin
            err_set[`ERR_ZERO_LEN] = len_zero;
            err_set[`ERR_RSVD] = (ctrl_q[`CTRL_RSVD_HI:`CTRL_RSVD_LO] != 7'h00);
            err_set[`ERR_ID] = (ctrl_q[`CTRL_ID_HI:`CTRL_ID_LO] != cur_id_q);
        end
        if (done_acc) begin
            err_set[`ERR_DONE_ORDER] = done_dir ? (done_id != wr_expect_q) :
                                                  (done_id != rd_expect_q);
        end
    end

    // APB slave and configuration
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            rd_base_q <= 64'h0000_0000_0000_0000;
            wr_base_q <= 64'h0000_0000_0000_0000;
            rd_last_q <= `LAST_PTR_NONE;
            wr_last_q <= `LAST_PTR_NONE;
            rd_size_q <= `TABLE_SIZE_RESET;
            wr_size_q <= `TABLE_SIZE_RESET;
            err_q     <= 4'h0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata  <= rdata_d;
                pslverr <= !addr_ok;
            end
            if (wr_acc) begin
                case (paddr[7:0])
                    `REG_RD_BASE_LO:    rd_base_q[31:0]  <= pwdata;
                    `REG_RD_BASE_HI:    rd_base_q[63:32] <= pwdata;
                    `REG_RD_LAST_PTR:   rd_last_q <= pwdata[7:0];
                    `REG_RD_TABLE_SIZE: rd_size_q <= pwdata[6:0];
                    `REG_WR_BASE_LO:    wr_base_q[31:0]  <= pwdata;
                    `REG_WR_BASE_HI:    wr_base_q[63:32] <= pwdata;
                    `REG_WR_LAST_PTR:   wr_last_q <= pwdata[7:0];
                    `REG_WR_TABLE_SIZE: wr_size_q <= pwdata[6:0];
                    default:            ;
                endcase
            end
            // Set wins over write-one-to-clear
            err_q <= (err_q & ~((wr_acc && paddr[7:0] == `REG_ERROR) ? pwdata[3:0] : 4'h0))
                     | err_set;
        end
    end

    // Fetch sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            beat_q     <= 3'h0;
            cur_dir_q  <= 1'b0;
            cur_id_q   <= 7'h00;
            rd_pend_q  <= 8'h00;
            wr_pend_q  <= 8'h00;
            rd_next_q  <= 7'h00;
            wr_next_q  <= 7'h00;
            fetch_req  <= 1'b0;
            fetch_addr <= 64'h0000_0000_0000_0000;
            src_lo_q   <= 32'h0000_0000;
            src_hi_q   <= 32'h0000_0000;
            dst_lo_q   <= 32'h0000_0000;
            dst_hi_q   <= 32'h0000_0000;
            ctrl_q     <= 32'h0000_0000;
            busy       <= 1'b0;
        end else begin
            rd_pend_q <= rd_pend_q + rd_add - ((start && rd_sel) ? 8'h01 : 8'h00);
            wr_pend_q <= wr_pend_q + wr_add - ((start && !rd_sel) ? 8'h01 : 8'h00);
            busy      <= start || (state_q != ST_IDLE) || (rd_pend_q != 8'h00)
                         || (wr_pend_q != 8'h00) || fifo_out_valid || desc_valid;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        cur_dir_q <= !rd_sel;
                        fetch_req <= 1'b1;
                        state_q   <= ST_REQ;
                        if (rd_sel) begin
                            cur_id_q   <= rd_next_q;
                            rd_next_q  <= id_next(rd_next_q, rd_size_q);
                            fetch_addr <= rd_base_q + `DESC_TABLE_OFFSET
                                          + {52'h0, rd_next_q, 5'h00};
                        end else begin
                            cur_id_q   <= wr_next_q;
                            wr_next_q  <= id_next(wr_next_q, wr_size_q);
                            fetch_addr <= wr_base_q + `DESC_TABLE_OFFSET
                                          + {52'h0, wr_next_q, 5'h00};
                        end
                    end
                end
                ST_REQ: begin
                    if (fetch_gnt) begin
                        fetch_req <= 1'b0;
                        beat_q    <= 3'h0;
                        state_q   <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (fetch_rvalid) begin
                        case (beat_q)
                            `BEAT_SRC_LO: src_lo_q <= fetch_rdata;
                            `BEAT_SRC_HI: src_hi_q <= fetch_rdata;
                            `BEAT_DST_LO: dst_lo_q <= fetch_rdata;
                            `BEAT_DST_HI: dst_hi_q <= fetch_rdata;
                            `BEAT_CTRL:   ctrl_q   <= fetch_rdata;
                            default:      ;
                        endcase
                        beat_q <= beat_q + 3'h1;
                        if (beat_q == `DESC_BEATS) begin
                            state_q <= ST_PUSH;
                        end
                    end
                end
                ST_PUSH: begin
                    if (len_zero || fifo_in_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Output stage toward the movers, in fetch order
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_valid    <= 1'b0;
            desc_dir      <= 1'b0;
            desc_id       <= 7'h00;
            desc_len_dw   <= 18'h00000;
            desc_src_addr <= 64'h0000_0000_0000_0000;
            desc_dst_addr <= 64'h0000_0000_0000_0000;
        end else if (out_load) begin
            desc_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                desc_dir      <= fifo_out_data[153];
                desc_id       <= fifo_out_data[152:146];
                desc_len_dw   <= fifo_out_data[145:128];
                desc_src_addr <= fifo_out_data[127:64];
                desc_dst_addr <= fifo_out_data[63:0];
            end
        end
    end

    // Done reporting into the status table
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ready  <= 1'b1;
            stat_req    <= 1'b0;
            stat_addr   <= 64'h0000_0000_0000_0000;
            stat_data   <= 32'h0000_0000;
            rd_expect_q <= 7'h00;
            wr_expect_q <= 7'h00;
        end else if (done_acc) begin
            done_ready <= 1'b0;
            stat_req   <= 1'b1;
            stat_data  <= `DONE_FLAG;
            if (done_dir) begin
                wr_expect_q <= id_next(done_id, wr_size_q);
                stat_addr   <= wr_base_q + {55'h0, done_id, 2'h0};
            end else begin
                rd_expect_q <= id_next(done_id, rd_size_q);
                stat_addr   <= rd_base_q + {55'h0, done_id, 2'h0};
            end
        end else if (stat_req && stat_gnt) begin
            stat_req   <= 1'b0;
            done_ready <= 1'b1;
        end
    end
endmodule // dma_descriptor_table_parser

//--- testbench/dma_parser_props_properties.sv
// Purpose: Port-level checks on the descriptor table parser
// Assumes: Single pclk domain, async active-low reset
// Notes:   Bound to the parser top below
`timescale 1ns/1ps
module dma_parser_props (
    input wire        pclk,
    input wire        presetn,
    input wire        fetch_req,
    input wire [63:0] fetch_addr,
    input wire        fetch_gnt,
    input wire        desc_valid,
    input wire        desc_ready,
    input wire        desc_dir,
    input wire [6:0]  desc_id,
    input wire [17:0] desc_len_dw,
    input wire [63:0] desc_src_addr,
    input wire [63:0] desc_dst_addr,
    input wire        done_valid,
    input wire        done_ready,
    input wire        stat_req,
    input wire [63:0] stat_addr,
    input wire [31:0] stat_data,
    input wire        stat_gnt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_fetch_hold;
        fetch_req && !fetch_gnt |=> fetch_req && $stable(fetch_addr);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch request dropped");
    property p_fetch_align;
        fetch_req |-> fetch_addr[4:0] == 5'h0;
    endproperty
    a_fetch_align: assert property (p_fetch_align) else $error("fetch off entry");
    property p_desc_hold;
        desc_valid && !desc_ready |=> desc_valid && $stable({desc_dir, desc_id,
            desc_len_dw, desc_src_addr, desc_dst_addr});
    endproperty
    a_desc_hold: assert property (p_desc_hold) else $error("descriptor changed");
    property p_len_nonzero;
        desc_valid |-> desc_len_dw != 18'h0;
    endproperty
    a_len_nonzero: assert property (p_len_nonzero) else $error("zero length out");
    property p_stat_data;
        stat_req |-> stat_data == 32'h1 && stat_addr[1:0] == 2'b00;
    endproperty
    a_stat_data: assert property (p_stat_data) else $error("bad status word");
    property p_stat_follows;
        done_valid && done_ready |=> stat_req && !done_ready;
    endproperty
    a_stat_follows: assert property (p_stat_follows) else $error("no status write");
    property p_stat_hold;
        stat_req && !stat_gnt |=> stat_req && $stable(stat_addr);
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("status request dropped");
    property p_done_reopen;
        stat_req && stat_gnt |=> !stat_req ##[0:1] done_ready;
    endproperty
    a_done_reopen: assert property (p_done_reopen) else $error("done not reopened");
endmodule // dma_parser_props

bind dma_descriptor_table_parser dma_parser_props u_props (.pclk, .presetn, .fetch_req,
    .fetch_addr, .fetch_gnt, .desc_valid, .desc_ready, .desc_dir, .desc_id, .desc_len_dw,
    .desc_src_addr, .desc_dst_addr, .done_valid, .done_ready, .stat_req, .stat_addr,
    .stat_data, .stat_gnt);

//--- testbench/dma_host_mem_model.sv
// Purpose: Host memory serving descriptor tables and granting status writes
// Assumes: Table bases have their low 12 bits clear
// Notes:   Random grant delay and beat gaps
`timescale 1ns/1ps
module dma_host_mem_model (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         fetch_req,
    input  wire  [63:0] fetch_addr,
    output logic        fetch_gnt,
    output logic        fetch_rvalid,
    output logic [31:0] fetch_rdata,
    input  wire         stat_req,
    output logic        stat_gnt
);
    int          seed = 32'h92483e06;
    int          k;
    logic [63:0] a;
    function [31:0] word(input int n, input [63:0] ad);
        logic [6:0] id;
        id = ad[11:5] - 7'h10;
        if (n < 4) word = {ad[35:32], n[3:0], 17'h0, id};
        else if (n == 4) word = {7'h0, id, (id == 7'h1) ? 18'h3ffff :
            (id == 7'h5) ? 18'h0 : {11'h0, id} + 18'h1};
        else word = 32'hffff_ffff;
    endfunction
    always @(posedge pclk or negedge presetn)
        if (!presetn) stat_gnt <= 1'b0;
        else stat_gnt <= stat_req && !stat_gnt && ($random(seed) & 1);
    initial begin
        fetch_gnt = 0;
        fetch_rvalid = 0;
        fetch_rdata = 0;
        forever begin
            @(posedge pclk);
            if (presetn && fetch_req && ($random(seed) & 1)) begin
                fetch_gnt <= 1;
                a = fetch_addr;
                @(posedge pclk);
                fetch_gnt <= 0;
                for (k = 0; k < 8; k++) begin
                    while (($random(seed) & 3) == 0) begin
                        fetch_rvalid <= 0;
                        fetch_rdata <= $random(seed);
                        @(posedge pclk);
                    end
                    fetch_rvalid <= 1;
                    fetch_rdata <= word(k, a);
                    @(posedge pclk);
                end
                fetch_rvalid <= 0;
                fetch_rdata <= ~fetch_rdata;
            end
        end
    end
endmodule // dma_host_mem_model

//--- testbench/dma_descriptor_table_parser_tb.sv
// Purpose: Self-checking bench for the descriptor table parser
// Assumes: Host model answers fetches and status writes
// Notes:   Read base 1_0000_0000, write base 2_0000_0000
`timescale 1ns/1ps
module dma_descriptor_table_parser_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, stall;
    logic        fetch_req, fetch_gnt, fetch_rvalid, desc_valid, desc_ready, desc_dir;
    logic        done_valid, done_ready, done_dir, stat_req, stat_gnt, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, fetch_rdata, stat_data;
    logic [63:0] fetch_addr, desc_src_addr, desc_dst_addr, stat_addr;
    logic [6:0]  desc_id, done_id, eid;
    logic [3:0]  tg;
    logic [17:0] desc_len_dw;
    logic [6:0]  q_rd[$], q_wr[$];
    int          mismatches, checked, seed, i;

    dma_descriptor_table_parser dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fetch_req, .fetch_addr, .fetch_gnt,
        .fetch_rvalid, .fetch_rdata, .desc_valid, .desc_ready, .desc_dir, .desc_id,
        .desc_len_dw, .desc_src_addr, .desc_dst_addr, .done_valid, .done_ready,
        .done_dir, .done_id, .stat_req, .stat_addr, .stat_data, .stat_gnt, .busy);
    dma_host_mem_model u_host (.pclk, .presetn, .fetch_req, .fetch_addr, .fetch_gnt,
        .fetch_rvalid, .fetch_rdata, .stat_req, .stat_gnt);

    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    function [31:0] wd(input int k, input [3:0] t, input [6:0] id);
        wd = {t, k[3:0], 17'h0, id};
    endfunction
    function [17:0] ln(input [6:0] id);
        ln = (id == 7'h1) ? 18'h3ffff : {11'h0, id} + 18'h1;
    endfunction
    task summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task fail;
        mismatches++;
        summarize;
    endtask
    task check(input [63:0] x, input [63:0] g);
        checked++;
        if (x !== g) begin
            mismatches++;
            $display("unexpected at %0t: exp %h got %h", $time, x, g);
        end
    endtask
    task apb(input logic w, input [11:0] a, input [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail;
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task drain;
        int n;
        n = 0;
        while (q_rd.size() + q_wr.size() != 0 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) fail;
    endtask
    task done_one(input logic d, input [6:0] id);
        int n;
        @(posedge pclk);
        done_valid <= 1;
        done_dir <= d;
        done_id <= id;
        n = 0;
        do begin @(posedge pclk); n++; end while (done_ready !== 1'b1 && n < 20);
        done_valid <= 0;
        do begin @(posedge pclk); n++; end while (!(stat_req && stat_gnt) && n < 80);
        if (n >= 80) fail;
        check((d ? 64'h2_0000_0000 : 64'h1_0000_0000) + {id, 2'b00}, stat_addr);
    endtask
    always @(posedge pclk) desc_ready <= !stall && (($random(seed) & 3) != 0);
    always @(posedge pclk) begin
        if (presetn && desc_valid === 1'b1 && desc_ready) begin
            if ((desc_dir ? q_wr.size() : q_rd.size()) == 0) fail;
            eid = desc_dir ? q_wr.pop_front() : q_rd.pop_front();
            tg = desc_dir ? 4'h2 : 4'h1;
            check(eid, desc_id);
            check(ln(eid), desc_len_dw);
            check({wd(1, tg, eid), wd(0, tg, eid)}, desc_src_addr);
            check({wd(3, tg, eid), wd(2, tg, eid)}, desc_dst_addr);
        end
    end
    initial begin
        seed = 32'h92483e06;
        {presetn, psel, penable, pwrite, paddr, pwdata, stall} = '0;
        {done_valid, done_dir, done_id} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h01c, 0);
        check(32'h7f, r);
        apb(0, 12'h008, 0);
        check(8'hff, r[7:0]);
        apb(0, 12'h028, 0);
        check(33'h1_0000_0000, {e, r});
        apb(1, 12'h004, 32'h1);
        apb(1, 12'h000, 32'h0);
        apb(1, 12'h00c, 32'h7);
        apb(1, 12'h014, 32'h2);
        apb(1, 12'h010, 32'h0);
        for (i = 0; i < 7; i++) if (i != 5) q_rd.push_back(i[6:0]);
        apb(1, 12'h008, 32'h6);
        drain;
        apb(0, 12'h024, 0);
        check(32'h1, r);
        apb(1, 12'h024, 32'h1);
        apb(0, 12'h024, 0);
        check(32'h0, r);
        for (i = 7; i < 10; i++) q_rd.push_back(i[6:0] & 7'h7);
        apb(1, 12'h008, 32'h1);
        drain;
        stall <= 1;
        for (i = 0; i < 40; i++) if (i != 5) q_wr.push_back(i[6:0]);
        apb(1, 12'h018, 32'd39);
        i = 0;
        do begin apb(0, 12'h020, 0); i++; end while (r[8:3] !== 6'h20 && i < 600);
        check(6'h20, r[8:3]);
        check(1'b1, r[0]);
        if (r[8:3] !== 6'h20) summarize;
        stall <= 0;
        drain;
        apb(0, 12'h020, 0);
        check(32'h0, r);
        apb(1, 12'h024, 32'hf);
        for (i = 0; i < 3; i++) done_one(1'b0, i[6:0]);
        for (i = 0; i < 2; i++) done_one(1'b1, i[6:0]);
        apb(0, 12'h024, 0);
        check(32'h0, r);
        done_one(1'b0, 7'h05);
        apb(0, 12'h024, 0);
        check(32'h8, r);
        summarize;
    end
endmodule // dma_descriptor_table_parser_tb
